/* hw/ued_dataflow.sv */
module ued_dataflow
    import ued_pkg::*;
#(
    parameter int FRAME_CYCLES = FRAME_CYCLES_DEF
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic SOF_ONLY_MODE,
    input wire logic SOF_PIN_MODE,
    input wire logic CMD_VALID,
    input wire logic [7:0] CMD_CODE,
    input wire logic RD_STB,
    output logic RD_VALID,
    output logic [7:0] RD_DATA,
    output logic INT_N,
    input wire logic SOF_PULSE,
    input wire logic BUS_RESET,
    input wire logic [NUM_EP-1:0] EP_STALLED,
    input wire logic TXN_VALID,
    input wire logic [2:0] TXN_EP,
    input wire ued_txn_t TXN_RESULT,
    input wire logic BUF_WR_VALID,
    input wire logic [2:0] BUF_WR_EP,
    input wire logic [7:0] BUF_WR_ADDR,
    input wire logic [7:0] BUF_WR_DATA,
    input wire logic DMA_DONE,
    input wire logic DMA_RD_STB,
    output logic DMA_READY,
    output logic DMA_VALID,
    output logic [7:0] DMA_DATA,
    output logic DMA_LAST,
    output logic SUSPENDED,
    output logic DEV_ENABLE
);
    logic [7:0] mem [0:MEM_BYTES-1];
    ued_cmd_t cmd_reg, cmd_next;
    logic [2:0] ep_reg, ep_next;
    logic [7:0] ptr_reg, ptr_next;
    logic idx_reg, idx_next;
    logic done_reg, done_next;
    logic [NUM_EP-1:0] epf_reg, epf_next;
    logic busrst_reg, busrst_next, susp_chg_reg, susp_chg_next, dmaf_reg, dmaf_next;
    ued_stat_t stat_reg [NUM_EP], stat_next [NUM_EP];
    logic [31:0] fcnt_reg, fcnt_next;
    logic [1:0] missed_reg, missed_next;
    logic susp_reg, susp_next, en_reg, en_next, sof_irq_reg, sof_irq_next;
    logic rd_valid_next, dma_valid_next, dma_last_next;
    logic [7:0] rd_data_next, dma_data_next, int_low, int_high, dptr;
    logic dma_take, cmd_sel, cmd_stat;

    function automatic int buf_index(input logic [2:0] ep, input logic [7:0] p);
        buf_index = int'(ep) * BUF_BYTES + int'(p);
    endfunction

    function automatic logic [7:0] bump(input logic [7:0] p);
        bump = (p < PTR_MAX) ? 8'(p + 8'h01) : p;
    endfunction

    // reserved high bits stay zero so firmware sees no phantom sources
    assign int_low = {susp_chg_reg, busrst_reg, epf_reg};
    assign int_high = {7'h00, dmaf_reg};
    // sof-only mode hides normal sources entirely
    assign INT_N = SOF_ONLY_MODE ? !sof_irq_reg
                 : !((|int_low) || (|int_high) || (SOF_PIN_MODE && sof_irq_reg));
    // micro strobe wins the shared buffer pointer; dma stalls that cycle
    assign DMA_READY = !RD_STB;
    assign dma_take = DMA_RD_STB && !RD_STB;
    assign dptr = (ptr_reg < PAYLOAD_IDX) ? PAYLOAD_IDX : ptr_reg;
    assign cmd_sel = CMD_VALID && CMD_CODE >= CMD_SEL_BASE && CMD_CODE < CMD_SEL_BASE + 8'(NUM_EP);
    assign cmd_stat = CMD_VALID && CMD_CODE >= CMD_STAT_BASE && CMD_CODE < CMD_STAT_BASE + 8'(NUM_EP);
    assign SUSPENDED = susp_reg;
    assign DEV_ENABLE = en_reg;

    always_comb begin
        cmd_next = cmd_reg;
        ep_next = ep_reg;
        ptr_next = ptr_reg;
        idx_next = idx_reg;
        done_next = done_reg;
        epf_next = epf_reg;
        busrst_next = busrst_reg;
        susp_chg_next = susp_chg_reg;
        dmaf_next = dmaf_reg;
        stat_next = stat_reg;
        fcnt_next = fcnt_reg;
        missed_next = missed_reg;
        susp_next = susp_reg;
        en_next = en_reg;
        sof_irq_next = SOF_PULSE;
        rd_valid_next = 1'b0;
        rd_data_next = RD_DATA;
        dma_valid_next = 1'b0;
        dma_data_next = DMA_DATA;
        dma_last_next = 1'b0;
        // command decode
        if (cmd_sel) begin
            cmd_next = CK_SELECT;
            ep_next = 3'(CMD_CODE - CMD_SEL_BASE);
            ptr_next = 8'h00;
            done_next = 1'b0;
        end else if (cmd_stat) begin
            cmd_next = CK_STATUS;
            ep_next = 3'(CMD_CODE - CMD_STAT_BASE);
            done_next = 1'b0;
        end else if (CMD_VALID && CMD_CODE == CMD_RDBUF) begin
            cmd_next = CK_RDBUF;
        end else if (CMD_VALID && CMD_CODE == CMD_INTSRC) begin
            cmd_next = CK_INTSRC;
            idx_next = 1'b0;
            done_next = 1'b0;
        end else if (CMD_VALID) begin
            cmd_next = CK_IDLE;
        end
        // data reads; extra select, status and interrupt reads return zero, buffer reads past the end repeat the last byte
        if (RD_STB && !CMD_VALID) begin
            rd_valid_next = 1'b1;
            rd_data_next = 8'h00;
            case (cmd_reg)
                CK_SELECT: begin
                    if (!done_reg) begin
                        rd_data_next[SEL_STALL_BIT] = EP_STALLED[ep_reg];
                    end
                    done_next = 1'b1;
                end
                CK_STATUS: begin
                    if (!done_reg) begin
                        rd_data_next = stat_reg[ep_reg];
                        stat_next[ep_reg] = '0;
                        epf_next[ep_reg] = 1'b0;
                    end
                    done_next = 1'b1;
                end
                CK_RDBUF: begin
                    rd_data_next = mem[buf_index(ep_reg, ptr_reg)];
                    ptr_next = bump(ptr_reg);
                end
                CK_INTSRC: begin
                    if (!done_reg && !idx_reg) begin
                        rd_data_next = int_low;
                        busrst_next = 1'b0;
                        susp_chg_next = 1'b0;
                        idx_next = 1'b1;
                    end else if (!done_reg) begin
                        rd_data_next = int_high;
                        dmaf_next = 1'b0;
                        done_next = 1'b1;
                    end
                end
                default: begin
                    rd_data_next = 8'h00;
                end
            endcase
        end
        // dma read: header bytes skipped, last byte from stored length
        if (dma_take) begin
            dma_valid_next = 1'b1;
            dma_data_next = mem[buf_index(ep_reg, dptr)];
            dma_last_next = (dptr >= 8'(mem[buf_index(ep_reg, HDR_LEN_IDX)] + 8'h01));
            // a select in the same cycle must still restart the pointer
            if (!cmd_sel) begin
                ptr_next = bump(dptr);
            end
        end
        // frame watchdog for suspend
        if (SOF_PULSE) begin
            fcnt_next = '0;
            missed_next = 2'h0;
            susp_next = 1'b0;
        end else if (fcnt_reg >= 32'(FRAME_CYCLES - 1)) begin
            fcnt_next = '0;
            if (missed_reg != MISSED_SOF_LIMIT) begin
                missed_next = 2'(missed_reg + 2'h1);
            end
        end else begin
            fcnt_next = 32'(fcnt_reg + 32'h1);
        end
        if (missed_next == MISSED_SOF_LIMIT) begin
            susp_next = 1'b1;
        end
        // hardware events set after the read clears so they win over them in the same cycle; a bus reset below still clears them
        if (susp_next != susp_reg) begin
            susp_chg_next = 1'b1;
        end
        if (DMA_DONE) begin
            dmaf_next = 1'b1;
        end
        if (TXN_VALID && TXN_EP < 3'(NUM_EP)) begin
            epf_next[TXN_EP] = 1'b1;
            stat_next[TXN_EP].overrun = stat_reg[TXN_EP].success || (stat_reg[TXN_EP].err != ERR_NONE)
                                      || epf_reg[TXN_EP];
            stat_next[TXN_EP].success = TXN_RESULT.success;
            // code 0111 is not a legal result and is never reported
            stat_next[TXN_EP].err = (TXN_RESULT.err == ERR_NEVER) ? ERR_NONE : TXN_RESULT.err;
            if (TXN_RESULT.success) begin
                stat_next[TXN_EP].setup = TXN_RESULT.setup && !TXN_EP[0];
                stat_next[TXN_EP].toggle = TXN_RESULT.toggle;
            end
        end
        // bus reset clears the state like a reset but enables the device and raises the bus reset flag
        if (BUS_RESET) begin
            cmd_next = CK_IDLE;
            ep_next = 3'h0;
            ptr_next = 8'h00;
            idx_next = 1'b0;
            done_next = 1'b0;
            epf_next = '0;
            stat_next = '{default: '0};
            dmaf_next = 1'b0;
            susp_chg_next = 1'b0;
            fcnt_next = '0;
            missed_next = 2'h0;
            susp_next = 1'b0;
            busrst_next = 1'b1;
            en_next = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            cmd_reg <= CK_IDLE;
            ep_reg <= 3'h0;
            ptr_reg <= 8'h00;
            idx_reg <= 1'b0;
            done_reg <= 1'b0;
            epf_reg <= '0;
            busrst_reg <= 1'b0;
            susp_chg_reg <= 1'b0;
            dmaf_reg <= 1'b0;
            stat_reg <= '{default: '0};
            fcnt_reg <= '0;
            missed_reg <= 2'h0;
            susp_reg <= 1'b0;
            en_reg <= 1'b0;
            sof_irq_reg <= 1'b0;
            RD_VALID <= 1'b0;
            RD_DATA <= 8'h00;
            DMA_VALID <= 1'b0;
            DMA_DATA <= 8'h00;
            DMA_LAST <= 1'b0;
        end else begin
            cmd_reg <= cmd_next;
            ep_reg <= ep_next;
            ptr_reg <= ptr_next;
            idx_reg <= idx_next;
            done_reg <= done_next;
            epf_reg <= epf_next;
            busrst_reg <= busrst_next;
            susp_chg_reg <= susp_chg_next;
            dmaf_reg <= dmaf_next;
            stat_reg <= stat_next;
            fcnt_reg <= fcnt_next;
            missed_reg <= missed_next;
            susp_reg <= susp_next;
            en_reg <= en_next;
            sof_irq_reg <= sof_irq_next;
            RD_VALID <= rd_valid_next;
            RD_DATA <= rd_data_next;
            DMA_VALID <= dma_valid_next;
            DMA_DATA <= dma_data_next;
            DMA_LAST <= dma_last_next;
        end
    end

    // buffer contents are not reset; byte 0 may hold anything
    always_ff @(posedge CLK) begin
        if (BUF_WR_VALID && BUF_WR_EP < 3'(NUM_EP) && BUF_WR_ADDR <= PTR_MAX) begin
            mem[buf_index(BUF_WR_EP, BUF_WR_ADDR)] <= BUF_WR_DATA;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    sequence s_int_cmd;
        CMD_VALID && CMD_CODE == CMD_INTSRC && !BUS_RESET;
    endsequence
    sequence s_plain_rd;
        RD_STB && !CMD_VALID && !BUS_RESET;
    endsequence

    a_sof_only_mask: assert property (SOF_ONLY_MODE && !$past(SRST) |-> INT_N == !$past(SOF_PULSE))
        else $error("normal source leaked in sof-only mode");
    a_normal_or: assert property (!SOF_ONLY_MODE && (|int_low || |int_high) |-> !INT_N)
        else $error("interrupt not raised for pending source");
    a_int_two_bytes: assert property (s_int_cmd ##1 s_plain_rd[*2] |=>
        RD_VALID && RD_DATA == {7'h00, $past(dmaf_reg)})
        else $error("second interrupt byte wrong");
    a_ep_flags_kept: assert property (cmd_reg == CK_INTSRC && RD_STB && !BUS_RESET |=>
        (epf_reg & $past(epf_reg)) == $past(epf_reg))
        else $error("endpoint flag cleared by interrupt read");
    a_bus_reset_up: assert property (BUS_RESET |=>
        busrst_reg && en_reg && ptr_reg == 8'h00 && (!INT_N || SOF_ONLY_MODE))
        else $error("bus reset did not flag and enable");
    a_susp_change: assert property (susp_reg != $past(susp_reg) && !$past(BUS_RESET) |-> susp_chg_reg)
        else $error("suspend transition not flagged");
    a_dma_done: assert property (DMA_DONE && !BUS_RESET |=> dmaf_reg)
        else $error("dma done flag not set");
    a_select_ptr: assert property (cmd_sel && !BUS_RESET |=> ptr_reg == 8'h00 && cmd_reg == CK_SELECT)
        else $error("select did not restart pointer");
    a_stat_clear: assert property (((cmd_reg == CK_STATUS && !done_reg && !TXN_VALID) and s_plain_rd) |=>
        !epf_reg[$past(ep_reg)] && stat_reg[$past(ep_reg)] == '0 && done_reg)
        else $error("status read did not clear flag");
    a_buf_inc: assert property (((cmd_reg == CK_RDBUF && ptr_reg < PTR_MAX) and s_plain_rd) |=>
        ptr_reg == 8'($past(ptr_reg) + 8'h01))
        else $error("buffer pointer did not advance");
    a_dma_skip: assert property (dma_take && ptr_reg < PAYLOAD_IDX && !CMD_VALID && !BUS_RESET |=>
        ptr_reg == 8'(PAYLOAD_IDX + 8'h01))
        else $error("dma read did not skip header");
endmodule

/* hw/ued_pkg.sv */
package ued_pkg;
    localparam int CLK_MHZ = 125;
    localparam int FRAME_US = 1000;
    localparam int FRAME_CYCLES_DEF = FRAME_US * CLK_MHZ;
    localparam int NUM_EP = 6;
    localparam int BUF_BYTES = 130;
    localparam int MEM_BYTES = NUM_EP * BUF_BYTES;
    localparam logic [1:0] MISSED_SOF_LIMIT = 2'h3;
    localparam logic [7:0] CMD_SEL_BASE = 8'h00;
    localparam logic [7:0] CMD_STAT_BASE = 8'h40;
    localparam logic [7:0] CMD_RDBUF = 8'hf0;
    localparam logic [7:0] CMD_INTSRC = 8'hf4;
    localparam logic [7:0] HDR_LEN_IDX = 8'h01;
    localparam logic [7:0] PAYLOAD_IDX = 8'h02;
    localparam logic [7:0] PTR_MAX = 8'h81;
    localparam int SEL_STALL_BIT = 1;
    localparam int INT_BUSRST_BIT = 6;
    localparam int INT_SUSP_BIT = 7;
    localparam int INT_DMA_BIT = 0;
    localparam logic [3:0] ERR_NONE = 4'h0;
    localparam logic [3:0] ERR_PID_ENC = 4'h1;
    localparam logic [3:0] ERR_PID_UNK = 4'h2;
    localparam logic [3:0] ERR_UNEXP = 4'h3;
    localparam logic [3:0] ERR_TOK_CRC = 4'h4;
    localparam logic [3:0] ERR_DATA_CRC = 4'h5;
    localparam logic [3:0] ERR_TIMEOUT = 4'h6;
    localparam logic [3:0] ERR_NEVER = 4'h7;
    localparam logic [3:0] ERR_EOP = 4'h8;
    localparam logic [3:0] ERR_NAK = 4'h9;
    localparam logic [3:0] ERR_STALL = 4'ha;
    localparam logic [3:0] ERR_OVERFLOW = 4'hb;
    localparam logic [3:0] ERR_BITSTUFF = 4'hd;
    localparam logic [3:0] ERR_WRONG_PID = 4'hf;
    typedef enum {CK_IDLE, CK_SELECT, CK_STATUS, CK_RDBUF, CK_INTSRC} ued_cmd_t;
    typedef struct packed {
        logic success;
        logic [3:0] err;
        logic setup;
        logic toggle;
    } ued_txn_t;
    typedef struct packed {
        logic overrun;
        logic toggle;
        logic setup;
        logic [3:0] err;
        logic success;
    } ued_stat_t;
endpackage

/* tb/ued_dataflow_tb_top.sv */
module ued_dataflow_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ued_pkg::*;
    // short frame so three missed frames fit in a few hundred cycles
    localparam int FC = 200;
    logic clk = 1'b0, srst = 1'b1, sof_only = 1'b0, sof_pin = 1'b0;
    logic cmd_valid, rd_stb, rd_valid, int_n, sof = 1'b0, busrst = 1'b0;
    logic [7:0] cmd_code, rd_data, dma_data, baddr = 8'h00, bdata = 8'h00;
    logic [5:0] stalled = 6'h29;
    logic txv = 1'b0, bwe = 1'b0, dma_done = 1'b0, dma_rd = 1'b0;
    logic [2:0] tep = 3'h0, bep = 3'h0;
    ued_txn_t tres = '0;
    logic dma_ready, dma_valid, dma_last, susp, dev_en;
    int mismatches = 0, total_checks = 0, cycles = 0;
    always #4 clk = ~clk;
    ued_micro u_mcu (.CLK(clk), .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code), .RD_STB(rd_stb),
        .RD_VALID(rd_valid), .RD_DATA(rd_data));
    ued_dataflow #(.FRAME_CYCLES(FC)) u_dut (.CLK(clk), .SRST(srst), .SOF_ONLY_MODE(sof_only),
        .SOF_PIN_MODE(sof_pin), .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code), .RD_STB(rd_stb),
        .RD_VALID(rd_valid), .RD_DATA(rd_data), .INT_N(int_n), .SOF_PULSE(sof), .BUS_RESET(busrst),
        .EP_STALLED(stalled), .TXN_VALID(txv), .TXN_EP(tep), .TXN_RESULT(tres), .BUF_WR_VALID(bwe),
        .BUF_WR_EP(bep), .BUF_WR_ADDR(baddr), .BUF_WR_DATA(bdata), .DMA_DONE(dma_done),
        .DMA_RD_STB(dma_rd), .DMA_READY(dma_ready), .DMA_VALID(dma_valid), .DMA_DATA(dma_data),
        .DMA_LAST(dma_last), .SUSPENDED(susp), .DEV_ENABLE(dev_en));
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            test_done();
        end
    end
    task automatic step(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic chk1(input string nm, input logic seen, input logic exp);
        chk(nm, {7'h00, seen}, {7'h00, exp});
    endtask
    task automatic rdchk(input string nm, input logic [7:0] exp);
        logic [7:0] d;
        u_mcu.rd(d);
        chk(nm, d, exp);
    endtask
    task automatic int_read(input logic [7:0] lo, input logic [7:0] hi);
        logic [7:0] d0, d1;
        u_mcu.burst(CMD_INTSRC, d0, d1);
        chk("int_lo", d0, lo);
        chk("int_hi", d1, hi);
    endtask
    task automatic pulse_sof();
        sof = 1'b1;
        step();
        sof = 1'b0;
        step();
    endtask
    task automatic txn(input logic [2:0] ep, input ued_txn_t r);
        tep = ep;
        tres = r;
        txv = 1'b1;
        step();
        txv = 1'b0;
        step();
    endtask
    task automatic stat_read(input logic [2:0] ep, input logic [7:0] exp);
        u_mcu.cmd(CMD_STAT_BASE + {5'h00, ep});
        rdchk("last_status", exp);
    endtask
    task automatic fill(input logic [2:0] ep, input logic [7:0] len, input logic [7:0] base);
        bwe = 1'b1;
        bep = ep;
        for (int i = 0; i < 6; i++) begin
            baddr = i[7:0];
            bdata = (i == 1) ? len : base + i[7:0];
            step();
        end
        bwe = 1'b0;
        step();
    endtask
    task automatic t_bus_reset();
        chk1("dev_en_srst", dev_en, 1'b0);
        busrst = 1'b1;
        step();
        busrst = 1'b0;
        step();
        chk1("dev_en", dev_en, 1'b1);
        chk1("int_n_set", int_n, 1'b0);
        int_read(8'h40, 8'h00);
        chk1("int_n_clr", int_n, 1'b1);
        $display("test bus_reset done");
    endtask
    task automatic t_status();
        pulse_sof();
        txn(3'd1, '{1'b1, ERR_NONE, 1'b1, 1'b1});
        chk1("int_n_ep", int_n, 1'b0);
        int_read(8'h02, 8'h00);
        int_read(8'h02, 8'h00);
        stat_read(3'd1, 8'h41);
        rdchk("status_extra", 8'h00);
        int_read(8'h00, 8'h00);
        stat_read(3'd1, 8'h00);
        txn(3'd0, '{1'b1, ERR_NONE, 1'b1, 1'b0});
        stat_read(3'd0, 8'h21);
        txn(3'd2, '{1'b0, ERR_TIMEOUT, 1'b1, 1'b1});
        txn(3'd2, '{1'b1, ERR_NONE, 1'b0, 1'b1});
        stat_read(3'd2, 8'hc1);
        $display("test status done");
    endtask
    task automatic t_errcodes();
        logic [3:0] codes[13] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hd, 4'hf};
        logic [3:0] c;
        pulse_sof();
        foreach (codes[i]) begin
            c = (codes[i] == 4'h7) ? 4'h0 : codes[i];
            txn(3'd4, '{1'b0, codes[i], 1'b0, 1'b0});
            stat_read(3'd4, {3'b000, c, 1'b0});
        end
        $display("test errcodes done");
    endtask
    task automatic t_select();
        pulse_sof();
        for (int e = 0; e < NUM_EP; e++) begin
            u_mcu.cmd(CMD_SEL_BASE + e[7:0]);
            rdchk("select", {6'h00, stalled[e], 1'b0});
        end
        $display("test select done");
    endtask
    task automatic t_rdbuf();
        logic [7:0] d;
        pulse_sof();
        fill(3'd2, 8'h08, 8'h10);
        u_mcu.cmd(8'h02);
        u_mcu.cmd(CMD_RDBUF);
        u_mcu.rd(d);
        rdchk("buf_len", 8'h08);
        rdchk("buf_b2", 8'h12);
        u_mcu.cmd(CMD_INTSRC);
        u_mcu.cmd(CMD_RDBUF);
        rdchk("buf_resume", 8'h13);
        u_mcu.cmd(8'h02);
        u_mcu.cmd(CMD_RDBUF);
        u_mcu.rd(d);
        rdchk("buf_restart", 8'h08);
        $display("test rdbuf done");
    endtask
    task automatic t_dma();
        logic [7:0] d;
        pulse_sof();
        fill(3'd3, 8'h03, 8'ha0);
        u_mcu.cmd(8'h03);
        chk1("dma_ready_idle", dma_ready, 1'b1);
        for (int k = 0; k < 3; k++) begin
            dma_rd = 1'b1;
            step();
            dma_rd = 1'b0;
            chk("dma_flags", {dma_valid, dma_last, 6'h00}, {1'b1, k == 2, 6'h00});
            chk("dma_data", dma_data, 8'ha2 + k[7:0]);
            step();
        end
        // micro read and dma request together: the micro wins the pointer
        fork
            u_mcu.rd(d);
            begin
                dma_rd = 1'b1;
                #1;
                chk1("dma_ready_busy", dma_ready, 1'b0);
                step();
                dma_rd = 1'b0;
                chk1("dma_held_off", dma_valid, 1'b0);
            end
        join
        chk("select_dma", d, 8'h02);
        dma_done = 1'b1;
        step();
        dma_done = 1'b0;
        step();
        int_read(8'h00, 8'h01);
        int_read(8'h00, 8'h00);
        $display("test dma done");
    endtask
    task automatic mode(input logic only, input logic pin, input logic exp);
        sof_only = only;
        sof_pin = pin;
        step();
        chk1("int_n_mode", int_n, exp);
    endtask
    task automatic sof_int(input logic exp);
        sof = 1'b1;
        step();
        sof = 1'b0;
        chk1("int_n_sof", int_n, exp);
        step();
    endtask
    task automatic t_modes();
        pulse_sof();
        dma_done = 1'b1;
        step();
        dma_done = 1'b0;
        mode(1'b0, 1'b0, 1'b0);
        mode(1'b1, 1'b0, 1'b1);
        sof_int(1'b0);
        chk1("int_n_after", int_n, 1'b1);
        mode(1'b0, 1'b1, 1'b0);
        mode(1'b1, 1'b1, 1'b1);
        mode(1'b0, 1'b0, 1'b0);
        int_read(8'h00, 8'h01);
        mode(1'b0, 1'b1, 1'b1);
        sof_int(1'b0);
        mode(1'b0, 1'b0, 1'b1);
        $display("test modes done");
    endtask
    task automatic t_suspend();
        int n;
        n = 0;
        pulse_sof();
        while (susp !== 1'b1 && n < 4 * FC) begin
            step();
            n++;
        end
        chk1("suspended", susp, 1'b1);
        chk1("int_n_susp", int_n, 1'b0);
        int_read(8'h80, 8'h00);
        pulse_sof();
        chk1("awake", susp, 1'b0);
        int_read(8'h80, 8'h00);
        $display("test suspend done");
    endtask
    initial begin
        repeat (6) @(posedge clk);
        #1;
        srst = 1'b0;
        t_bus_reset();
        t_status();
        t_errcodes();
        t_select();
        t_rdbuf();
        t_dma();
        t_modes();
        t_suspend();
        test_done();
    end
endmodule

/* tb/ued_micro.sv */
module ued_micro
    import ued_pkg::*;
(
    input wire logic CLK,
    output logic CMD_VALID,
    output logic [7:0] CMD_CODE,
    output logic RD_STB,
    input wire logic RD_VALID,
    input wire logic [7:0] RD_DATA
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        CMD_VALID = 1'b0;
        CMD_CODE = 8'h00;
        RD_STB = 1'b0;
    end
    // callers enter just after an edge; one idle cycle closes each access
    task automatic cmd(input logic [7:0] code);
        CMD_CODE = code;
        CMD_VALID = 1'b1;
        @(posedge CLK);
        #1;
        CMD_VALID = 1'b0;
        CMD_CODE = ~code;
        @(posedge CLK);
        #1;
    endtask
    // no valid answer gives x, so a missing strobe never reads as data
    task automatic rd(output logic [7:0] d);
        RD_STB = 1'b1;
        @(posedge CLK);
        #1;
        d = (RD_VALID === 1'b1) ? RD_DATA : 8'hxx;
        RD_STB = 1'b0;
        @(posedge CLK);
        #1;
    endtask
    // command with two reads right behind it, the tightest legal spacing
    task automatic burst(input logic [7:0] code, output logic [7:0] d0, output logic [7:0] d1);
        CMD_CODE = code;
        CMD_VALID = 1'b1;
        @(posedge CLK);
        #1;
        CMD_VALID = 1'b0;
        CMD_CODE = ~code;
        RD_STB = 1'b1;
        @(posedge CLK);
        #1;
        d0 = (RD_VALID === 1'b1) ? RD_DATA : 8'hxx;
        @(posedge CLK);
        #1;
        d1 = (RD_VALID === 1'b1) ? RD_DATA : 8'hxx;
        RD_STB = 1'b0;
        @(posedge CLK);
        #1;
    endtask
endmodule
